// *** design/eep_pkg.sv ***
// Shared constants and enumerations of the serial EEPROM target port.
// Assumes a 200 MHz system clock; no other dependency.
package eep_pkg;

    // ----------------------------------------
    // Array geometry
    // ----------------------------------------
    localparam int ADDR_W     = 13;
    localparam int PAGE_AW    = 5;
    localparam int PAGE_BYTES = 32;
    localparam int MEM_BYTES  = 8192;
    localparam logic [3:0] DEV_TYPE = 4'hA;

    // ----------------------------------------
    // Bit counter marks within a nine-clock frame
    // ----------------------------------------
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_ACK  = 4'h9;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_WR_MS       = 5;
    localparam int T_WR_NS       = T_WR_MS * 1000000;
    localparam int WR_CYC        = T_WR_NS / CLK_PERIOD_NS;

    // ----------------------------------------
    // Synchroniser width and state enumerations
    // ----------------------------------------
    localparam int SYNC_W = 7;

    typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_SEND, ST_PROG} eep_st_t;
    typedef enum logic [1:0] {PH_DEV, PH_AHI, PH_ALO, PH_DATA} eep_ph_t;

endpackage : eep_pkg

// *** design/eep_slave_port.sv ***
// Two-wire serial EEPROM target port with an 8192 x 8 array.
// Assumes bus pull-ups and pad pull-downs on the strap pins.
`timescale 1ns/100ps
module eep_slave_port
    import eep_pkg::*;
#(
    parameter int PROG_CYCLES = WR_CYC
) (
    // System
    input  wire logic clk_i,
    input  wire logic srst_i,
    // Two-wire bus
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_o,
    // Straps
    input  wire logic chip_select_bit2_i,
    input  wire logic chip_select_bit1_i,
    input  wire logic chip_select_bit0_i,
    input  wire logic wp_i,
    // Status
    output logic      prog_busy_o
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        eep_st_t              st;
        eep_ph_t              ph;
        logic [3:0]           cnt;
        logic [7:0]           sh;
        logic [7:0]           tx;
        logic                 rw;
        logic                 mack;
        logic [4:0]           ahi;
        logic [ADDR_W-1:0]    addr;
        logic [5:0]           nby;
        logic [31:0]          pbv;
        logic [31:0][7:0]     pbuf;
        logic [31:0]          pcnt;
        logic                 scl_q;
        logic                 scl_qq;
        logic                 sda_q;
        logic                 oe;
        logic                 sda;
        logic                 busy;
    } eep_state_t;

    eep_state_t r;
    eep_state_t r_nxt;

    logic [7:0]        mem [MEM_BYTES];
    logic              mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [7:0]        mem_wd;
    logic [7:0]        rd_byte;

    // ----------------------------------------
    // Link domain capture
    // ----------------------------------------
    // Sample on rising SCL.
    // The bit stays put for a whole SCL period, so it crosses as a level.
    logic link_bit_r;

    always_ff @(posedge scl_i) begin
        link_bit_r <= sda_i;
    end

    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    logic [SYNC_W-1:0] sync_q;
    logic scl_s;
    logic sda_s;
    logic bit_s;
    logic wp_s;
    logic [2:0] cs_s;

    eep_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk_i (clk_i),
        .d_i   ({scl_i, sda_i, link_bit_r, wp_i,
                 chip_select_bit2_i, chip_select_bit1_i,
                 chip_select_bit0_i}),
        .q_o   (sync_q)
    );

    assign scl_s = sync_q[6];
    assign sda_s = sync_q[5];
    assign bit_s = sync_q[4];
    assign wp_s  = sync_q[3];
    assign cs_s  = sync_q[2:0];

    // ----------------------------------------
    // Bus events
    // ----------------------------------------
    logic ev_rise;
    logic ev_fall;
    logic ev_start;
    logic ev_stop;
    logic dev_match;

    // SCL edges use one extra stage so the captured bit has settled.
    assign ev_rise = r.scl_q & ~r.scl_qq;
    assign ev_fall = ~r.scl_q & r.scl_qq;

    // SDA moving with SCL high is a condition, not data.
    assign ev_start = scl_s & r.scl_q & r.sda_q & ~sda_s;
    assign ev_stop = scl_s & r.scl_q & ~r.sda_q & sda_s;

    // Type code, then strap match; straps pulled low.
    assign dev_match = (r.sh[7:4] == DEV_TYPE) && (r.sh[3:1] == cs_s);

    // Flat byte array addressed by the 13-bit counter.
    assign rd_byte = mem[r.addr];

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        r_nxt = r;
        mem_we = 1'h0;
        mem_wa = {r.addr[ADDR_W-1:PAGE_AW], r.pcnt[PAGE_AW-1:0]};
        mem_wd = r.pbuf[r.pcnt[PAGE_AW-1:0]];
        r_nxt.scl_q = scl_s;
        r_nxt.scl_qq = r.scl_q;
        r_nxt.sda_q = sda_s;
        // The data output is always low; only the enable moves.
        r_nxt.sda = 1'h0;
        unique case (r.st)
            ST_PROG: begin
                // Bus ignored; no acknowledge while busy.
                r_nxt.oe = 1'h0;
                if (r.pcnt < 32'(PAGE_BYTES)) begin
                    mem_we = r.pbv[r.pcnt[PAGE_AW-1:0]];
                end
                // Fixed cycle count within the write time.
                if (r.pcnt == 32'(PROG_CYCLES - 1)) begin
                    r_nxt.st = ST_IDLE;
                    r_nxt.busy = 1'h0;
                    r_nxt.pbv = '0;
                    r_nxt.nby = '0;
                end else begin
                    r_nxt.pcnt = r.pcnt + 32'h1;
                end
            end
            ST_IDLE, ST_RECV, ST_SEND: begin
                if (ev_start) begin
                    // A START opens a command; drop pending data.
                    r_nxt.st = ST_RECV;
                    r_nxt.ph = PH_DEV;
                    r_nxt.cnt = '0;
                    r_nxt.oe = 1'h0;
                    r_nxt.pbv = '0;
                    r_nxt.nby = '0;
                end else if (ev_stop) begin
                    r_nxt.oe = 1'h0;
                    // Written data plus STOP launches programming.
                    // A high write-protect level skips it.
                    if (r.st == ST_RECV && r.ph == PH_DATA &&
                        r.nby != '0 && !wp_s) begin
                        r_nxt.st = ST_PROG;
                        r_nxt.pcnt = '0;
                        r_nxt.busy = 1'h1;
                    end else begin
                        r_nxt.st = ST_IDLE;
                        r_nxt.pbv = '0;
                        r_nxt.nby = '0;
                    end
                end else if (r.st == ST_RECV) begin
                    if (ev_rise && r.cnt < BIT_LAST) begin
                        r_nxt.sh = {r.sh[6:0], bit_s};
                        r_nxt.cnt = r.cnt + 4'h1;
                    end else if (ev_fall && r.cnt == BIT_LAST) begin
                        r_nxt.cnt = BIT_ACK;
                        r_nxt.oe = 1'h1;
                        unique case (r.ph)
                            PH_DEV: begin
                                if (!dev_match) begin
                                    r_nxt.st = ST_IDLE;
                                    r_nxt.oe = 1'h0;
                                end
                                r_nxt.rw = r.sh[0];
                            end
                            PH_AHI: begin
                                r_nxt.ahi = r.sh[4:0];
                            end
                            PH_ALO: begin
                                // Second address byte loads the counter.
                                r_nxt.addr = {r.ahi, r.sh};
                            end
                            PH_DATA: begin
                                // Bytes land in the page buffer.
                                r_nxt.pbuf[r.addr[PAGE_AW-1:0]] = r.sh;
                                r_nxt.pbv[r.addr[PAGE_AW-1:0]] = 1'h1;
                                // Step and wrap within the page.
                                r_nxt.addr[PAGE_AW-1:0] = r.addr[PAGE_AW-1:0] + 5'h1;
                                if (r.nby != 6'h20) begin
                                    r_nxt.nby = r.nby + 6'h1;
                                end
                            end
                        endcase
                    end else if (ev_fall && r.cnt == BIT_ACK) begin
                        r_nxt.cnt = '0;
                        r_nxt.oe = 1'h0;
                        if (r.ph == PH_DEV && r.rw) begin
                            // Read starts at the counter, then steps.
                            r_nxt.st = ST_SEND;
                            r_nxt.tx = rd_byte;
                            r_nxt.oe = ~rd_byte[7];
                            r_nxt.addr = r.addr + 13'h1;
                        end else if (r.ph != PH_DATA) begin
                            // Advance to the next byte of the write.
                            r_nxt.ph = eep_ph_t'(r.ph + 2'h1);
                        end
                    end
                end else if (r.st == ST_SEND) begin
                    if (ev_rise && r.cnt < BIT_LAST) begin
                        r_nxt.cnt = r.cnt + 4'h1;
                    end else if (ev_rise && r.cnt == BIT_LAST) begin
                        // Controller acknowledge sampled on the ninth clock.
                        r_nxt.mack = ~bit_s;
                        r_nxt.cnt = BIT_ACK;
                    end else if (ev_fall && r.cnt != '0 && r.cnt < BIT_LAST) begin
                        // Next bit goes out after the falling edge.
                        r_nxt.tx = {r.tx[6:0], 1'h0};
                        r_nxt.oe = ~r.tx[6];
                    end else if (ev_fall && r.cnt == BIT_LAST) begin
                        r_nxt.oe = 1'h0;
                    end else if (ev_fall && r.cnt == BIT_ACK) begin
                        if (r.mack) begin
                            // Next byte; the counter wraps at the top.
                            r_nxt.tx = rd_byte;
                            r_nxt.oe = ~rd_byte[7];
                            r_nxt.addr = r.addr + 13'h1;
                            r_nxt.cnt = '0;
                        end else begin
                            r_nxt.st = ST_IDLE;
                            r_nxt.oe = 1'h0;
                        end
                    end
                end
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Reset leaves the port idle and silent.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    // Array contents survive reset, as stored cells would.
    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign sda_o       = r.sda;
    assign sda_oe_o    = r.oe;
    assign prog_busy_o = r.busy;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_start_enter: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ev_start && r.st != ST_PROG |=> r.st == ST_RECV && r.ph == PH_DEV && r.cnt == '0)
        else $error("START did not open a command");

    chk_ack_match: assert property (
        @(posedge clk_i) disable iff (srst_i)
        r.st == ST_RECV && ev_fall && r.cnt == BIT_LAST && r.ph == PH_DEV && dev_match
        && !ev_start && !ev_stop |=> sda_oe_o && r.st == ST_RECV)
        else $error("Matching address not acknowledged");

    chk_nack_miss: assert property (
        @(posedge clk_i) disable iff (srst_i)
        r.st == ST_RECV && ev_fall && r.cnt == BIT_LAST && r.ph == PH_DEV && !dev_match
        && !ev_start && !ev_stop |=> !sda_oe_o && r.st == ST_IDLE)
        else $error("Mismatched address not dropped");

    chk_prog_quiet: assert property (
        @(posedge clk_i) disable iff (srst_i)
        r.st == ST_PROG |-> !sda_oe_o && prog_busy_o)
        else $error("Bus driven during programming");

    chk_prog_bound: assert property (
        @(posedge clk_i) disable iff (srst_i)
        r.st == ST_PROG |-> r.pcnt < 32'(PROG_CYCLES))
        else $error("Programming ran past its time");

    chk_stop_launch: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ev_stop && r.st == ST_RECV && r.ph == PH_DATA && r.nby != '0 && !wp_s
        |=> r.st == ST_PROG ##1 r.st == ST_PROG)
        else $error("STOP after data did not program");

    chk_wp_block: assert property (
        @(posedge clk_i) disable iff (srst_i)
        ev_stop && wp_s && r.st != ST_PROG |=> r.st == ST_IDLE && !prog_busy_o)
        else $error("Write protect did not block programming");

    chk_page_step: assert property (
        @(posedge clk_i) disable iff (srst_i)
        r.st == ST_RECV && ev_fall && r.cnt == BIT_LAST && r.ph == PH_DATA
        && !ev_start && !ev_stop
        |=> r.addr[12:5] == $past(r.addr[12:5])
            && r.addr[4:0] == $past(r.addr[4:0]) + 5'h1)
        else $error("Page address stepped wrongly");

    chk_read_step: assert property (
        @(posedge clk_i) disable iff (srst_i)
        r.st == ST_SEND && ev_fall && r.cnt == BIT_ACK && r.mack && !ev_start && !ev_stop
        |=> r.addr == $past(r.addr) + 13'h1 && r.cnt == '0)
        else $error("Read counter did not step");

    chk_drive_low: assert property (
        @(posedge clk_i) disable iff (srst_i)
        sda_oe_o |-> !sda_o)
        else $error("SDA driven high");

endmodule : eep_slave_port

// *** design/eep_sync.sv ***
// Two flip-flop synchroniser for a group of independent levels.
// Assumes each bit changes slowly compared with the clock.
`timescale 1ns/100ps
module eep_sync
    import eep_pkg::*;
#(
    parameter int W = 1
) (
    // Clock
    input  wire logic         clk_i,
    // Levels
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] hold;
    } eep_sync_t;

    eep_sync_t s_r;
    eep_sync_t s_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        s_nxt.meta = d_i;
        s_nxt.hold = s_r.meta;
    end

    always_ff @(posedge clk_i) begin
        s_r <= s_nxt;
    end

    assign q_o = s_r.hold;

endmodule : eep_sync

// *** sim/eep_ctrl_model.sv ***
// Two-wire bus controller model that drives the EEPROM target port.
// Assumes the bench resolves SDA from both pull-down enables and a pull-up.
`timescale 1ns/100ps
module eep_ctrl_model #(
    parameter int HALF_NS = 32
) (
    // Bus
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    // ----------------------------------------
    // Bus sequencing
    // ----------------------------------------
    // SCL stands high between frames; it only toggles inside a command.
    initial begin
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic start();
        sda_oe_o = 1'b0;
        #(HALF_NS) scl_o = 1'b1;
        #(HALF_NS) sda_oe_o = 1'b1;
        #(HALF_NS) scl_o = 1'b0;
    endtask : start

    task automatic stop();
        #4 sda_oe_o = 1'b1;
        #(HALF_NS) scl_o = 1'b1;
        #(HALF_NS) sda_oe_o = 1'b0;
        #(HALF_NS);
    endtask : stop

    // Bit slots.
    // SDA moves just after the fall, so the target never mistakes data for a condition.
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #4 sda_oe_o = ~tx[i];
            #(HALF_NS - 4) rx[i] = sda_i;
            scl_o = 1'b1;
            #(HALF_NS) scl_o = 1'b0;
        end
    endtask : xfer
endmodule : eep_ctrl_model

// *** sim/test_eep_slave_port.sv ***
// Self-checking bench of the two-wire EEPROM target port.
// Assumes the controller model in eep_ctrl_model.sv and a pull-up on SDA.
`timescale 1ns/100ps
module test_eep_slave_port;
    // A short programming time keeps the run small; polling still fits inside it.
    localparam int PROG_N = 2000;

    logic       clk_i;
    logic       srst_i;
    logic       scl;
    logic       sda;
    logic       ctrl_oe;
    logic       sda_o;
    logic       sda_oe_o;
    logic [2:0] cs;
    logic       wp;
    logic       prog_busy_o;
    logic [8:0] rx;
    int         mismatches;
    int         n_checks;
    int         busy_cnt = 0;
    int         busy_mark;

    // ----------------------------------------
    // Wiring
    // ----------------------------------------
    // SDA is a wired-AND with a pull-up; either side may pull it low.
    assign sda = ~(ctrl_oe | (sda_oe_o & ~sda_o));

    eep_slave_port #(.PROG_CYCLES(PROG_N)) DUT (
        .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .chip_select_bit2_i(cs[2]), .chip_select_bit1_i(cs[1]),
        .chip_select_bit0_i(cs[0]), .wp_i(wp), .prog_busy_o(prog_busy_o));

    eep_ctrl_model ctrl (.sda_i(sda), .scl_o(scl), .sda_oe_o(ctrl_oe));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (prog_busy_o === 1'b1)
            busy_cnt <= busy_cnt + 1;
        if (sda_oe_o === 1'b1 && sda_o !== 1'b0)
            chk_bit("sda_o", 1'b0, sda_o);
    end

    // ----------------------------------------
    // Compare and bus helpers
    // ----------------------------------------
    task automatic chk_bit(input string nm, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk_bit

    task automatic chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_byte

    task automatic chk_num(input string nm, input int exp, input int got);
        n_checks++;
        if (got != exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
        end
    endtask : chk_num

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic pins(input logic [2:0] c, input logic w);
        @(posedge clk_i);
        #1;
        cs = c;
        wp = w;
    endtask : pins

    task automatic dev(input logic [3:0] typ, input logic [2:0] c, input logic rd);
        ctrl.start();
        ctrl.xfer({typ, c, rd, 1'b1}, rx);
    endtask : dev

    // The junk bits fill the unused top of the high address byte.
    task automatic addr(input logic [12:0] a, input logic [2:0] junk);
        dev(4'hA, cs, 1'b0);
        chk_bit("ack_dev", 1'b0, rx[0]);
        ctrl.xfer({junk, a[12:8], 1'b1}, rx);
        chk_bit("ack_hi", 1'b0, rx[0]);
        ctrl.xfer({a[7:0], 1'b1}, rx);
        chk_bit("ack_lo", 1'b0, rx[0]);
    endtask : addr

    task automatic wr(input logic [12:0] a, input int n, input logic [31:0] d);
        addr(a, 3'b101);
        for (int i = 0; i < n; i++) begin
            ctrl.xfer({d[31 - 8 * i -: 8], 1'b1}, rx);
            chk_bit("ack_data", 1'b0, rx[0]);
        end
        busy_mark = busy_cnt;
        ctrl.stop();
    endtask : wr

    // The controller refuses the last byte, then stops.
    task automatic rd_cur(input int n, input logic [23:0] exp);
        dev(4'hA, cs, 1'b1);
        chk_bit("ack_rd", 1'b0, rx[0]);
        for (int i = 0; i < n; i++) begin
            ctrl.xfer({8'hFF, 1'(i == n - 1)}, rx);
            chk_byte("rd_data", exp[23 - 8 * i -: 8], rx[8:1]);
        end
        ctrl.stop();
    endtask : rd_cur

    task automatic rd_from(input logic [12:0] a, input int n, input logic [23:0] exp);
        addr(a, 3'b000);
        rd_cur(n, exp);
    endtask : rd_from

    task automatic wait_prog(input int exp);
        int k;
        k = 0;
        while (prog_busy_o !== 1'b0 && k < 4 * PROG_N) begin
            @(posedge clk_i);
            k++;
        end
        #1;
        chk_num("busy_cycles", exp, busy_cnt - busy_mark);
    endtask : wait_prog

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk_bit("sda_oe_o", 1'b0, sda_oe_o);
        chk_bit("prog_busy_o", 1'b0, prog_busy_o);
        $display("test reset done");
    endtask : t_reset

    task automatic t_select();
        pins(3'b000, 1'b0);
        dev(4'hA, 3'b000, 1'b0);
        chk_bit("ack_low_straps", 1'b0, rx[0]);
        ctrl.stop();
        pins(3'b101, 1'b0);
        dev(4'hA, 3'b100, 1'b0);
        chk_bit("nack_straps", 1'b1, rx[0]);
        ctrl.stop();
        dev(4'hB, 3'b101, 1'b0);
        chk_bit("nack_type", 1'b1, rx[0]);
        ctrl.stop();
        dev(4'hA, 3'b101, 1'b0);
        chk_bit("ack_match", 1'b0, rx[0]);
        ctrl.stop();
        $display("test select done");
    endtask : t_select

    task automatic t_write_poll();
        wr(13'h0123, 1, 32'h5A000000);
        dev(4'hA, cs, 1'b0);
        chk_bit("poll_busy", 1'b1, rx[0]);
        ctrl.stop();
        wait_prog(PROG_N);
        dev(4'hA, cs, 1'b0);
        chk_bit("poll_ready", 1'b0, rx[0]);
        ctrl.stop();
        $display("test write and poll done");
    endtask : t_write_poll

    task automatic t_abandon();
        busy_mark = busy_cnt;
        rd_from(13'h0123, 1, 24'h5A0000);
        chk_num("busy_cycles", 0, busy_cnt - busy_mark);
        $display("test random read done");
    endtask : t_abandon

    task automatic t_page();
        wr(13'h1FFE, 4, 32'h11223344);
        wait_prog(PROG_N);
        wr(13'h0000, 1, 32'h77000000);
        wait_prog(PROG_N);
        rd_from(13'h1FFE, 3, 24'h112277);
        rd_from(13'h1FE0, 2, 24'h334400);
        $display("test page wrap done");
    endtask : t_page

    task automatic t_wp();
        pins(3'b101, 1'b1);
        wr(13'h0000, 1, 32'hEE000000);
        repeat (20) @(posedge clk_i);
        chk_num("busy_cycles", 0, busy_cnt - busy_mark);
        rd_from(13'h0000, 1, 24'h770000);
        pins(3'b101, 1'b0);
        $display("test write protect done");
    endtask : t_wp

    initial begin
        srst_i     = 1'b1;
        cs         = 3'b101;
        wp         = 1'b0;
        mismatches = 0;
        n_checks   = 0;
        busy_mark  = 0;
        repeat (6) @(posedge clk_i);
        #1 srst_i = 1'b0;
        repeat (8) @(posedge clk_i);
        t_reset();
        t_select();
        t_write_poll();
        t_abandon();
        t_page();
        t_wp();
        conclude();
    end

    // About 50 bytes at 0.6 us each plus three 10 us programming spans; twice that is allowed.
    initial begin
        #(120_000);
        mismatches++;
        conclude();
    end
endmodule : test_eep_slave_port
